// ---- core/mrpf_regs.svh ----
// Register offsets, field positions, reset values and fixed constants
`ifndef MRPF_REGS_SVH
`define MRPF_REGS_SVH
`define MRPF_MGMT_CTRL_OFF 9'h000
`define MRPF_HOST_RXCTL_OFF 9'h004
`define MRPF_MFV_OFF 9'h008
`define MRPF_M2H_OFF 9'h00C
`define MRPF_STATUS_OFF 9'h010
`define MRPF_RULE_BASE 9'h020
`define MRPF_FPORT01_OFF 9'h040
`define MRPF_FPORT23_OFF 9'h044
`define MRPF_FPAT0_OFF 9'h048
`define MRPF_FPAT1_OFF 9'h04C
`define MRPF_FMASK_OFF 9'h050
`define MRPF_UC_BASE 9'h080
`define MRPF_MC_BASE 9'h100
`define MRPF_MC_VALID_BIT 31
`define MRPF_UC_AV_BIT 31
`define MRPF_CSUM_EN_BIT 0
`define MRPF_ARP_IPDIS_BIT 1
`define MRPF_M2H_EN_BIT 2
`define MRPF_PROM_UC_BIT 0
`define MRPF_PROM_MC_BIT 1
`define MRPF_MFV_MAC_BIT 0
`define MRPF_MFV_IP6_LSB 4
`define MRPF_RST_32 32'h0000_0000
`define MRPF_RST_8 8'h00
`define MRPF_AND_MASK 32'h0000_004F
`define MRPF_OR_MASK 32'h3000_FFB0
`define MRPF_B_UC_AND 0
`define MRPF_B_BC_AND 1
`define MRPF_B_VLAN 2
`define MRPF_B_IP 3
`define MRPF_B_UC_OR 4
`define MRPF_B_BC_OR 5
`define MRPF_B_MC 6
`define MRPF_B_ARP_REQ 7
`define MRPF_B_ARP_RSP 8
`define MRPF_B_NS 9
`define MRPF_B_P298 10
`define MRPF_B_P26F 11
`define MRPF_B_FPORT 12
`define MRPF_B_FPAT 28
`define MRPF_PORT_A 16'h0298
`define MRPF_PORT_B 16'h026F
`define MRPF_NS_TYPE 8'h87
`define MRPF_FLEX_WIN 128
`define MRPF_UC_N 16
`define MRPF_MC_N 8
`define MRPF_RULE_N 8
`define MRPF_MGMT_UC_IDX 15
`endif

// ---- core/mrpf_pkg.sv ----
// Types shared by the receive filter and its bench
package mrpf_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_DECIDE = 2'b11
	} mrpf_state_type;
	typedef struct packed {
		logic [47:0] dst_mac;
		logic vlan_hit;
		logic ip_hit;
		logic arp_req;
		logic arp_rsp;
		logic [7:0] icmp6_type;
		logic [3:0] ipv6_hit;
		logic l4_vld;
		logic [15:0] l4_dport;
		logic csum_ok;
	} mrpf_info_type;
	typedef struct packed {
		logic to_mgmt;
		logic to_host;
		logic drop;
		logic [7:0] rule_hits;
	} mrpf_dec_type;
endpackage

// ---- core/mrpf_filter.sv ----
// Manageability receive filter with classic Wishbone register slave
// Functional notes
// - L2 pass on promiscuous or matching unicast, multicast, or any broadcast.
// - Broadcast frames bypass VLAN check, treated as matched.
// - Full address checked against 16 unicast entries; last is management.
// - Multicast compares 12 destination bits against host-owned entries.
// - Detect external ARP requests and ARP responses.
// - Neighbor solicitation type 135 matched against enabled IPv6 entries.
// - Two fixed port filters, 0x26F and 0x298.
// - Four flex port filters, each a 16-bit word.
// - Two flex patterns searched within first 128 frame bytes.
// - Host access to flex storage drops frames received meanwhile.
// - Checksum enable requires correct L3/L4 checksums for management.
// - Eight rules; 0 to 6 by software, 7 by receive enable command.
// - Any enabled rule hit sends frame to management, maybe host.
// - An all-zero rule is disabled.
// - All enabled AND inputs must match.
// - Enabled OR inputs need one match; none enabled means ignored.
// - Rule bits 0,1,2,3,6 AND; bits 4,5 OR.
// - OR bits 7..15 and 29:28; 27:16 and 31:30 reserved.
// - Control bit disables IP check on ARP matches.
// - Host copy only with forward enable and per-rule forward bit.
`include "mrpf_regs.svh"
module mrpf_filter #(
	parameter int FLEX_WIN_BYTES = `MRPF_FLEX_WIN
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rcv_en_cmd_i,
	input wire logic [31:0] rcv_en_rule_i,
	input wire logic frm_sof_i,
	input wire logic frm_byte_vld_i,
	input wire logic [7:0] frm_byte_i,
	input wire logic frm_eof_i,
	input wire mrpf_pkg::mrpf_info_type frm_info_i,
	output logic dec_vld_o,
	output mrpf_pkg::mrpf_dec_type dec_o
);
	import mrpf_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Register storage
	logic [31:0] mctl_r;
	logic [31:0] hctl_r;
	logic [31:0] mfv_r;
	logic [7:0] m2h_r;
	logic [31:0] rule_r [`MRPF_RULE_N];
	logic [31:0] fport_r [2];
	logic [31:0] fpat_r [2];
	logic [31:0] fmask_r;
	logic [31:0] uc_lo_r [`MRPF_UC_N];
	logic [31:0] uc_hi_r [`MRPF_UC_N];
	logic [31:0] mc_r [`MRPF_MC_N];
	logic ack_r;
	logic [31:0] rdat_r;

	// Frame tracking
	mrpf_state_type st_r;
	mrpf_state_type st_nxt;
	mrpf_info_type info_r;
	logic [7:0] bcnt_r;
	logic [31:0] win_r;
	logic [1:0] fhit_r;
	logic drop_r;
	mrpf_dec_type dec_r;
	logic dvld_r;

	// Bus decode
	wire [8:0] adr = wb_adr_i[8:0];
	wire req = wb_cyc_i & wb_stb_i;
	wire wr_go = req & wb_we_i & ack_r;
	wire hit_rule = adr[8:5] == 4'h1;
	wire hit_uc = adr[8:7] == 2'b01;
	wire hit_mc = adr[8:5] == 4'h8;
	wire [2:0] rule_idx = adr[4:2];
	wire [3:0] uc_idx = adr[6:3];
	wire uc_hi_sel = adr[2];
	wire [2:0] mc_idx = adr[4:2];
	wire hit_flex = (adr == `MRPF_FPORT01_OFF) | (adr == `MRPF_FPORT23_OFF)
		| (adr == `MRPF_FPAT0_OFF) | (adr == `MRPF_FPAT1_OFF)
		| (adr == `MRPF_FMASK_OFF);
	wire flex_acc = req & hit_flex;
	wire [31:0] status = {14'h0000, dec_r.to_host, dec_r.to_mgmt, dec_r.rule_hits,
		5'h00, drop_r, st_r};
	wire [31:0] uc_rd = uc_hi_sel ? uc_hi_r[uc_idx] : uc_lo_r[uc_idx];
	wire [31:0] rd_data =
		(adr == `MRPF_MGMT_CTRL_OFF) ? mctl_r :
		(adr == `MRPF_HOST_RXCTL_OFF) ? hctl_r :
		(adr == `MRPF_MFV_OFF) ? mfv_r :
		(adr == `MRPF_M2H_OFF) ? {24'h000000, m2h_r} :
		(adr == `MRPF_STATUS_OFF) ? status :
		hit_rule ? rule_r[rule_idx] :
		(adr == `MRPF_FPORT01_OFF) ? fport_r[0] :
		(adr == `MRPF_FPORT23_OFF) ? fport_r[1] :
		(adr == `MRPF_FPAT0_OFF) ? fpat_r[0] :
		(adr == `MRPF_FPAT1_OFF) ? fpat_r[1] :
		(adr == `MRPF_FMASK_OFF) ? fmask_r :
		hit_uc ? uc_rd :
		hit_mc ? mc_r[mc_idx] :
		`MRPF_RST_32;

	// Bus answer, one wait state
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_r <= 1'b0;
			rdat_r <= `MRPF_RST_32;
		end else if (ce_i) begin
			ack_r <= req & ~ack_r;
			rdat_r <= rd_data;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// Control registers
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mctl_r <= `MRPF_RST_32;
			hctl_r <= `MRPF_RST_32;
			mfv_r <= `MRPF_RST_32;
			m2h_r <= `MRPF_RST_8;
			fmask_r <= `MRPF_RST_32;
		end else if (ce_i && wr_go) begin
			if (adr == `MRPF_MGMT_CTRL_OFF)
				mctl_r <= merge(mctl_r, wb_dat_i, wb_sel_i);
			if (adr == `MRPF_HOST_RXCTL_OFF)
				hctl_r <= merge(hctl_r, wb_dat_i, wb_sel_i);
			if (adr == `MRPF_MFV_OFF)
				mfv_r <= merge(mfv_r, wb_dat_i, wb_sel_i);
			if (adr == `MRPF_M2H_OFF && wb_sel_i[0])
				m2h_r <= wb_dat_i[7:0];
			if (adr == `MRPF_FMASK_OFF)
				fmask_r <= merge(fmask_r, wb_dat_i, wb_sel_i);
		end
	end

	// Decision rules; rule 7 loads only from receive enable command
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < `MRPF_RULE_N; i++) begin
				rule_r[i] <= `MRPF_RST_32;
			end
		end else if (ce_i) begin
			if (wr_go && hit_rule && rule_idx != 3'h7)
				rule_r[rule_idx] <= merge(rule_r[rule_idx], wb_dat_i, wb_sel_i);
			if (rcv_en_cmd_i)
				rule_r[7] <= rcv_en_rule_i;
		end
	end

	// Flex port words and patterns
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < 2; i++) begin
				fport_r[i] <= `MRPF_RST_32;
				fpat_r[i] <= `MRPF_RST_32;
			end
		end else if (ce_i && wr_go) begin
			if (adr == `MRPF_FPORT01_OFF)
				fport_r[0] <= merge(fport_r[0], wb_dat_i, wb_sel_i);
			if (adr == `MRPF_FPORT23_OFF)
				fport_r[1] <= merge(fport_r[1], wb_dat_i, wb_sel_i);
			if (adr == `MRPF_FPAT0_OFF)
				fpat_r[0] <= merge(fpat_r[0], wb_dat_i, wb_sel_i);
			if (adr == `MRPF_FPAT1_OFF)
				fpat_r[1] <= merge(fpat_r[1], wb_dat_i, wb_sel_i);
		end
	end

	// Address tables
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < `MRPF_UC_N; i++) begin
				uc_lo_r[i] <= `MRPF_RST_32;
				uc_hi_r[i] <= `MRPF_RST_32;
			end
			for (int i = 0; i < `MRPF_MC_N; i++) begin
				mc_r[i] <= `MRPF_RST_32;
			end
		end else if (ce_i && wr_go) begin
			if (hit_uc && !uc_hi_sel)
				uc_lo_r[uc_idx] <= merge(uc_lo_r[uc_idx], wb_dat_i, wb_sel_i);
			if (hit_uc && uc_hi_sel)
				uc_hi_r[uc_idx] <= merge(uc_hi_r[uc_idx], wb_dat_i, wb_sel_i);
			if (hit_mc)
				mc_r[mc_idx] <= merge(mc_r[mc_idx], wb_dat_i, wb_sel_i);
		end
	end

	// Frame state machine
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (frm_sof_i)
					st_nxt = ST_RECV;
			end
			ST_RECV: begin
				if (frm_eof_i)
					st_nxt = ST_DECIDE;
			end
			ST_DECIDE: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// Flex pattern window
	wire byte_in = (st_r == ST_RECV) & frm_byte_vld_i;
	wire [31:0] win_nxt = {win_r[23:0], frm_byte_i};
	wire in_win = (bcnt_r >= 8'd3) & (bcnt_r < 8'(FLEX_WIN_BYTES));
	logic [1:0] pat_eq;
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			pat_eq[p] = |fmask_r[p*4 +: 4];
			for (int k = 0; k < 4; k++) begin
				if (fmask_r[p*4 + k] && win_nxt[k*8 +: 8] != fpat_r[p][k*8 +: 8])
					pat_eq[p] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= ST_IDLE;
			bcnt_r <= 8'h00;
			win_r <= `MRPF_RST_32;
			fhit_r <= 2'b00;
			drop_r <= 1'b0;
			info_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE && frm_sof_i) begin
				bcnt_r <= 8'h00;
				fhit_r <= 2'b00;
				drop_r <= flex_acc;
			end else begin
				if (st_r == ST_RECV && flex_acc)
					drop_r <= 1'b1;
				if (byte_in) begin
					win_r <= win_nxt;
					if (bcnt_r != 8'hFF)
						bcnt_r <= bcnt_r + 8'h01;
					if (in_win)
						fhit_r <= fhit_r | pat_eq;
				end
			end
			if (st_r == ST_RECV && frm_eof_i)
				info_r <= frm_info_i;
		end
	end

	// L2 classification
	wire [47:0] da = info_r.dst_mac;
	wire is_bc = &da;
	wire is_mc = da[40] & ~is_bc;
	wire is_uc = ~da[40];
	logic uc_hit;
	logic mc_hit;
	always_comb begin
		uc_hit = 1'b0;
		for (int i = 0; i < `MRPF_UC_N; i++) begin
			if (uc_hi_r[i][`MRPF_UC_AV_BIT] && {uc_hi_r[i][15:0], uc_lo_r[i]} == da)
				uc_hit = 1'b1;
		end
		mc_hit = 1'b0;
		for (int i = 0; i < `MRPF_MC_N; i++) begin
			if (mc_r[i][`MRPF_MC_VALID_BIT] && mc_r[i][11:0] == da[47:36])
				mc_hit = 1'b1;
		end
	end
	wire mg_uc = uc_hi_r[`MRPF_MGMT_UC_IDX][`MRPF_UC_AV_BIT]
		& mfv_r[`MRPF_MFV_MAC_BIT]
		& ({uc_hi_r[`MRPF_MGMT_UC_IDX][15:0], uc_lo_r[`MRPF_MGMT_UC_IDX]} == da);
	wire l2_pass = (is_uc & hctl_r[`MRPF_PROM_UC_BIT]) | (is_uc & uc_hit)
		| (is_mc & hctl_r[`MRPF_PROM_MC_BIT]) | (is_mc & mc_hit) | is_bc;

	// L3/L4 inputs
	wire vlan_ok = is_bc | info_r.vlan_hit;
	wire arp_ip = mctl_r[`MRPF_ARP_IPDIS_BIT] | info_r.ip_hit;
	wire arp_req = info_r.arp_req & arp_ip;
	wire arp_rsp = info_r.arp_rsp & arp_ip;
	wire ns_hit = (info_r.icmp6_type == `MRPF_NS_TYPE)
		& |(info_r.ipv6_hit & mfv_r[`MRPF_MFV_IP6_LSB +: 4]);
	wire p_a = info_r.l4_vld & (info_r.l4_dport == `MRPF_PORT_A);
	wire p_b = info_r.l4_vld & (info_r.l4_dport == `MRPF_PORT_B);
	logic [3:0] fp_hit;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			fp_hit[i] = info_r.l4_vld & (info_r.l4_dport == fport_r[i/2][(i%2)*16 +: 16]);
		end
	end

	// Input vector aligned to rule bits
	logic [31:0] in_vec;
	always_comb begin
		in_vec = `MRPF_RST_32;
		in_vec[`MRPF_B_UC_AND] = mg_uc;
		in_vec[`MRPF_B_BC_AND] = is_bc;
		in_vec[`MRPF_B_VLAN] = vlan_ok;
		in_vec[`MRPF_B_IP] = info_r.ip_hit;
		in_vec[`MRPF_B_UC_OR] = mg_uc;
		in_vec[`MRPF_B_BC_OR] = is_bc;
		in_vec[`MRPF_B_MC] = is_mc;
		in_vec[`MRPF_B_ARP_REQ] = arp_req;
		in_vec[`MRPF_B_ARP_RSP] = arp_rsp;
		in_vec[`MRPF_B_NS] = ns_hit;
		in_vec[`MRPF_B_P298] = p_a;
		in_vec[`MRPF_B_P26F] = p_b;
		in_vec[`MRPF_B_FPORT +: 4] = fp_hit;
		in_vec[`MRPF_B_FPAT +: 2] = fhit_r;
	end

	// Rule evaluation
	logic [7:0] hits;
	always_comb begin
		for (int r = 0; r < `MRPF_RULE_N; r++) begin
			hits[r] = (|rule_r[r])
				& ~|(rule_r[r] & `MRPF_AND_MASK & ~in_vec)
				& (~|(rule_r[r] & `MRPF_OR_MASK)
				| |(rule_r[r] & `MRPF_OR_MASK & in_vec));
		end
	end
	wire csum_ok = ~mctl_r[`MRPF_CSUM_EN_BIT] | info_r.csum_ok;
	wire to_mgmt = ~drop_r & l2_pass & csum_ok & |hits;
	wire fwd_host = mctl_r[`MRPF_M2H_EN_BIT] & |(hits & m2h_r);
	wire to_host = ~drop_r & l2_pass & (~to_mgmt | fwd_host);

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dec_r <= '0;
			dvld_r <= 1'b0;
		end else if (ce_i) begin
			dvld_r <= st_r == ST_DECIDE;
			if (st_r == ST_DECIDE) begin
				dec_r.to_mgmt <= to_mgmt;
				dec_r.to_host <= to_host;
				dec_r.drop <= drop_r;
				dec_r.rule_hits <= hits;
			end
		end
	end
	assign dec_vld_o = dvld_r;
	assign dec_o = dec_r;
endmodule

// ---- testbench/mrpf_filter_props.sv ----
// Port checks for the receive filter
module mrpf_filter_props (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic frm_eof_i,
	input wire logic dec_vld_o,
	input wire mrpf_pkg::mrpf_dec_type dec_o
);
	import mrpf_pkg::*;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_eof;
		frm_eof_i && ce_i;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
		else $error("ack not next cycle");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_UNMAP_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i[8:0] >= 9'h120
		|-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	AST_DEC_LAT: assert property (s_eof |-> ##2 dec_vld_o)
		else $error("decision late");
	AST_DEC_ONE: assert property (dec_vld_o |=> !dec_vld_o)
		else $error("decision pulse too long");
	AST_DEC_CAUSE: assert property ($rose(dec_vld_o) |-> $past(frm_eof_i, 2))
		else $error("decision without frame end");
	AST_DEC_HOLD: assert property (!dec_vld_o |-> $stable(dec_o))
		else $error("decision changed between pulses");
	AST_DROP_NONE: assert property (dec_vld_o && dec_o.drop
		|-> !dec_o.to_mgmt && !dec_o.to_host) else $error("dropped frame forwarded");
	AST_MGMT_HIT: assert property (dec_vld_o && dec_o.to_mgmt
		|-> dec_o.rule_hits != 8'h00) else $error("management without rule hit");
endmodule
bind mrpf_filter mrpf_filter_props props_u (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .frm_eof_i(frm_eof_i), .dec_vld_o(dec_vld_o), .dec_o(dec_o)
);

// ---- testbench/mrpf_src_model.sv ----
// Receive datapath model feeding frames to the filter
module mrpf_src_model (
	input wire logic clk_i,
	output logic sof_o,
	output logic vld_o,
	output logic [7:0] byte_o,
	output logic eof_o,
	output mrpf_pkg::mrpf_info_type info_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import mrpf_pkg::*;
	initial begin
		sof_o = 1'b0;
		vld_o = 1'b0;
		byte_o = 8'h5A;
		eof_o = 1'b0;
		info_o = '0;
	end
	task automatic send(input mrpf_info_type inf, input int n);
		sof_o <= 1'b1;
		info_o <= ~inf;
		@(posedge clk_i);
		sof_o <= 1'b0;
		for (int k = 0; k < n; k++) begin
			vld_o <= 1'b1;
			byte_o <= k[7:0];
			eof_o <= (k == n - 1);
			if (k == n - 1) info_o <= inf;
			@(posedge clk_i);
		end
		vld_o <= 1'b0;
		eof_o <= 1'b0;
		info_o <= ~inf;
		byte_o <= ~byte_o;
	endtask
endmodule

// ---- testbench/mrpf_filter_tb.sv ----
// Self-checking bench for the receive filter
module mrpf_filter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mrpf_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic rcv_cmd = 1'b0;
	logic ce = 1'b1;
	logic [31:0] rcv_rule = 32'h0;
	logic [31:0] dat_o;
	logic ack, dec_vld, sof, bvld, eof;
	logic [7:0] bt;
	mrpf_info_type info;
	mrpf_dec_type dec;
	int failures = 0;
	int num_checks = 0;
	localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] UC = 48'h1022_3344_5566;
	localparam logic [47:0] MC = 48'h0100_5E00_0001;
	always #5 ref_clk = ~ref_clk;
	mrpf_filter dut_u (
		.ref_clk_i(ref_clk), .arst_n_i(arst_n), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rcv_en_cmd_i(rcv_cmd), .rcv_en_rule_i(rcv_rule), .frm_sof_i(sof),
		.frm_byte_vld_i(bvld), .frm_byte_i(bt), .frm_eof_i(eof), .frm_info_i(info),
		.dec_vld_o(dec_vld), .dec_o(dec)
	);
	mrpf_src_model pm_u (
		.clk_i(ref_clk), .sof_o(sof), .vld_o(bvld), .byte_o(bt), .eof_o(eof), .info_o(info)
	);
	task automatic summarize;
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {23'h0, a};
		wdat <= d;
		@(posedge ref_clk);
		while (ack !== 1'b1) @(posedge ref_clk);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	function automatic mrpf_info_type mk(input logic [47:0] m, input logic [15:0] p);
		mk = '{dst_mac: m, l4_vld: 1'b1, l4_dport: p, csum_ok: 1'b1, default: '0};
	endfunction
	task automatic go(input mrpf_info_type f, input logic [10:0] e, input logic [10:0] m = 11'h7FF);
		int n;
		n = 0;
		pm_u.send(f, 6);
		while (dec_vld !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(dec_vld), 32'h1);
		chk(32'(dec & m), 32'(e));
		@(posedge ref_clk);
	endtask
	task automatic t_regs;
		rd(9'h020, 32'h0);
		bus(1'b1, 9'h020, 32'h0000_0402);
		rd(9'h020, 32'h0000_0402);
		rd(9'h00C, 32'h0);
		bus(1'b1, 9'h00C, 32'h0000_01FF);
		rd(9'h00C, 32'h0000_00FF);
		bus(1'b1, 9'h03C, 32'h0000_0002);
		rd(9'h03C, 32'h0);
		rd(9'h1FC, 32'h0);
		bus(1'b1, 9'h00C, 32'h0);
	endtask
	task automatic t_bcast;
		bus(1'b1, 9'h020, 32'h0000_0006);
		go(mk(BC, 16'h0), 11'h401);
		bus(1'b1, 9'h000, 32'h0000_0004);
		bus(1'b1, 9'h00C, 32'h0000_0001);
		go(mk(BC, 16'h0), 11'h601);
		bus(1'b1, 9'h000, 32'h0);
		bus(1'b1, 9'h020, 32'h0);
		go(mk(BC, 16'h0), 11'h200);
	endtask
	task automatic t_ports;
		mrpf_info_type f;
		bus(1'b1, 9'h020, 32'h0000_0400);
		go(mk(BC, 16'h0298), 11'h401);
		go(mk(BC, 16'h026F), 11'h200);
		bus(1'b1, 9'h020, 32'h0000_0800);
		go(mk(BC, 16'h026F), 11'h401);
		bus(1'b1, 9'h000, 32'h0000_0001);
		f = mk(BC, 16'h026F);
		f.csum_ok = 1'b0;
		go(f, 11'h000, 11'h400);
		bus(1'b1, 9'h000, 32'h0);
	endtask
	task automatic t_uc;
		bus(1'b1, 9'h0F8, 32'h3344_5566);
		bus(1'b1, 9'h0FC, 32'h8000_1022);
		bus(1'b1, 9'h008, 32'h0000_0001);
		bus(1'b1, 9'h020, 32'h0000_0001);
		go(mk(UC, 16'h0), 11'h401);
		go(mk(UC ^ 48'h1, 16'h0), 11'h000);
		bus(1'b1, 9'h020, 32'h0);
		bus(1'b1, 9'h004, 32'h0000_0001);
		go(mk(UC ^ 48'h1, 16'h0), 11'h200);
		bus(1'b1, 9'h004, 32'h0);
		bus(1'b1, 9'h020, 32'h0000_0040);
		go(mk(MC, 16'h0), 11'h000, 11'h600);
		bus(1'b1, 9'h100, 32'h8000_0010);
		go(mk(MC, 16'h0), 11'h401);
		bus(1'b1, 9'h020, 32'h0);
	endtask
	task automatic t_l3;
		mrpf_info_type f;
		f = mk(BC, 16'h0);
		f.arp_req = 1'b1;
		bus(1'b1, 9'h020, 32'h0000_0180);
		go(f, 11'h200);
		bus(1'b1, 9'h000, 32'h0000_0002);
		go(f, 11'h401);
		bus(1'b1, 9'h000, 32'h0);
		f.arp_req = 1'b0;
		f.arp_rsp = 1'b1;
		f.ip_hit = 1'b1;
		go(f, 11'h401);
		f = mk(BC, 16'h0);
		f.icmp6_type = 8'h87;
		f.ipv6_hit = 4'h2;
		bus(1'b1, 9'h008, 32'h0000_0011);
		bus(1'b1, 9'h020, 32'h0000_0200);
		go(f, 11'h200);
		f.ipv6_hit = 4'h1;
		go(f, 11'h401);
		bus(1'b1, 9'h044, 32'hABCD_0000);
		bus(1'b1, 9'h020, 32'h0000_8000);
		go(mk(BC, 16'hABCD), 11'h401);
		go(mk(BC, 16'hABCE), 11'h200);
		bus(1'b1, 9'h048, 32'h0000_0003);
		bus(1'b1, 9'h050, 32'h0000_0001);
		bus(1'b1, 9'h020, 32'h1000_0000);
		go(mk(BC, 16'h0), 11'h401);
		bus(1'b1, 9'h048, 32'h0000_0009);
		go(mk(BC, 16'h0), 11'h200);
		bus(1'b1, 9'h020, 32'h0);
	endtask
	task automatic t_rule7;
		ce <= 1'b0;
		rcv_rule <= 32'h0000_0020;
		rcv_cmd <= 1'b1;
		@(posedge ref_clk);
		rcv_cmd <= 1'b0;
		ce <= 1'b1;
		@(posedge ref_clk);
		rd(9'h03C, 32'h0);
		rcv_rule <= 32'h0000_0002;
		rcv_cmd <= 1'b1;
		@(posedge ref_clk);
		rcv_cmd <= 1'b0;
		@(posedge ref_clk);
		rd(9'h03C, 32'h0000_0002);
		go(mk(BC, 16'h0), 11'h480);
		rcv_rule <= 32'h0;
		rcv_cmd <= 1'b1;
		@(posedge ref_clk);
		rcv_cmd <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic t_flex;
		bus(1'b1, 9'h020, 32'h0000_0002);
		fork
			go(mk(BC, 16'h0), 11'h100, 11'h700);
			begin
				repeat (2) @(posedge ref_clk);
				bus(1'b1, 9'h040, 32'h0000_0001);
			end
		join
		go(mk(BC, 16'h0), 11'h401);
	endtask
	initial begin
		#200000;
		failures++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_bcast();
		t_ports();
		t_uc();
		t_rule7();
		t_flex();
		t_l3();
		summarize();
	end
endmodule
